// >>> hdl/rwc_pkg.sv
// Constants for the reset and watchdog controller
// Operation
// R1 - Any reset forces registers to initial values; code keeps the reset cause flags through all but power-on
// R2 - Port reset acts asynchronously without clock
// R3 - Stretch internal reset by fuse-chosen delay
// R4 - Four sources: power-on, pin, watchdog, brown-out
// R5 - Power-on low reasserts reset immediately
// R6 - Power-on threshold crossing starts delay counter
// R7 - Low enabled pin resets even without clock
// R8 - Pin release starts delay, then processor runs
// R9 - Brown-out asserts immediately, releases through delay
// R10 - Level fuse selects trip level with hysteresis
// R11 - Filter supply dips shorter than minimum duration
// R12 - Watchdog reset pulse lasts one clock cycle
// R13 - Watchdog counts 128kHz oscillator ticks via prescaler
// R14 - Restart, disable and chip reset clear counter
// R15 - Ten selectable watchdog periods, reset on expiry; code also accepts prescale codes 10 to 15, giving two longer periods
// R16 - Watchdog can interrupt instead of reset
// R17 - Fuse picks safety level one or two
// R18 - Bandgap on for brown-out, comparator, or converter
// R19 - Change enable self-clears after four cycles
// R20 - Enable and irq-enable bits choose watchdog action
// R21 - Watchdog cause flag set on reset, cleared otherwise; code clears it only on power-on or a written zero
// R22 - Delay length is input, counted in oscillator ticks
package rwc_pkg;
	// Bus register offsets
	localparam logic [3:0] WDT_CTRL_OFFSET  = 4'h0;
	localparam logic [3:0] RST_CAUSE_OFFSET = 4'h4;
	localparam logic [3:0] REF_CTRL_OFFSET  = 4'h8;
	// Watchdog control field positions
	localparam int WDT_IF_BIT   = 7;
	localparam int WDT_IE_BIT   = 6;
	localparam int WDT_P3_BIT   = 5;
	localparam int WDT_CE_BIT   = 4;
	localparam int WDT_EN_BIT   = 3;
	// Reset cause field positions
	localparam int CAUSE_WDT_BIT = 3;
	localparam int CAUSE_BOD_BIT = 2;
	localparam int CAUSE_EXT_BIT = 1;
	localparam int CAUSE_POR_BIT = 0;
	// Reference control field positions
	localparam int REF_COMPARATOR_BANDGAP_SELECT_BIT = 0;
	localparam int REF_ADC_BIT  = 1;
	// Timing
	localparam int CLK_HZ           = 100_000_000;
	localparam int WDT_OSC_HZ       = 128_000;
	localparam int WDT_OSC_DIV      = CLK_HZ / WDT_OSC_HZ;
	localparam int CE_WINDOW_CYCLES = 4;
	localparam int WDT_PERIODS      = 10;
	localparam int WDT_BASE_LOG2    = 11;
	localparam int BOD_MIN_NS       = 2000;
	localparam int BOD_FILTER_CYC   = (BOD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [7:0] WDT_CTRL_RESET = 8'h00;
	localparam logic [1:0] BOD_LEVEL_OFF = 2'h3;
endpackage

// >>> hdl/rwc_sync_filter.sv
// Persistence filter for a brown-out comparator level
`timescale 1ns/1ps
module rwc_sync_filter #(
	parameter int CYCLES = 200
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Level in and filtered level out
	input  wire logic raw_i,
	output logic      filt_o
);
	logic [$clog2(CYCLES+1)-1:0] cnt_reg;

	// Dips shorter than the filter time are ignored
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			filt_o  <= 1'b0;
		end else if (!raw_i) begin
			cnt_reg <= '0;
			filt_o  <= 1'b0;
		end else if (cnt_reg == ($clog2(CYCLES+1))'(CYCLES)) begin
			filt_o <= 1'b1; // see R11
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule

// >>> hdl/rwc_delay_counter.sv
// Start-up delay counter stretching internal reset
`timescale 1ns/1ps
module rwc_delay_counter #(
	parameter int WIDTH = 16
) (
	// Clock and source reset
	input  wire logic             clk_i,
	input  wire logic             src_rst_i,
	// Oscillator tick and length
	input  wire logic             tick_i,
	input  wire logic [WIDTH-1:0] length_i,
	// Stretched reset
	output logic                  hold_o
);
	logic [WIDTH-1:0] cnt_reg;

	// Source active resets instantly; release counts ticks
	always_ff @(posedge clk_i or posedge src_rst_i) begin
		if (src_rst_i) begin
			cnt_reg <= '0;
			hold_o  <= 1'b1; // see R2
		end else if (hold_o && tick_i) begin
			if (cnt_reg >= length_i) begin
				hold_o <= 1'b0; // see R3
			end else begin
				cnt_reg <= cnt_reg + 1'b1; // see R22
			end
		end
	end
endmodule

// >>> hdl/rwc_top.sv
// Reset combiner, brown-out filter and watchdog timer
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module rwc_top #(
	parameter int DELAY_WIDTH = 16,
	parameter int BOD_FILTER  = rwc_pkg::BOD_FILTER_CYC,
	parameter int OSC_DIV     = rwc_pkg::WDT_OSC_DIV
) (
	// Clock and power-on
	input  wire logic                   REF_CLK_I,
	input  wire logic                   RST_I,
	// Analog detectors and pin
	input  wire logic                   SUPPLY_BELOW_POR_I,
	input  wire logic                   EXT_RESET_N_I,
	input  wire logic                   EXT_RESET_EN_I,
	input  wire logic                   BOD_BELOW_LOW_I,
	input  wire logic                   BOD_ABOVE_HIGH_I,
	// Fuses
	input  wire logic [2:0]             BROWNOUT_LEVEL_FUSE_I,
	input  wire logic                   WATCHDOG_ALWAYS_ON_FUSE_I,
	input  wire logic [DELAY_WIDTH-1:0] STARTUP_DELAY_I,
	// CPU side
	input  wire logic                   WATCHDOG_RESTART_INSTRUCTION_I,
	input  wire logic                   WDT_IRQ_ACK_I,
	input  wire logic                   ADC_ENABLE_I,
	// Wishbone slave
	input  wire logic                   CYC_I,
	input  wire logic                   STB_I,
	input  wire logic                   WE_I,
	input  wire logic [3:0]             ADR_I,
	input  wire logic [3:0]             SEL_I,
	input  wire logic [31:0]            DAT_I,
	output logic      [31:0]            DAT_O,
	output logic                        ACK_O,
	// Results
	output logic                        INT_RESET_O,
	output logic                        IO_RESET_O,
	output logic                        WDT_RESET_PULSE_O,
	output logic                        WDT_IRQ_O,
	output logic                        BANDGAP_EN_O,
	output logic [2:0]                  BROWNOUT_LEVEL_O
);
	logic        bod_enabled;
	logic        bod_low_filt;
	logic        bod_active_reg;
	logic        ext_active;
	logic        wdt_pulse_reg;
	logic        src_rst;
	logic        delay_hold;
	logic        tick_reg;
	logic [$clog2(OSC_DIV+1)-1:0] div_reg;
	logic [21:0] wdt_cnt_reg;
	logic [3:0]  wdt_prescale_reg;
	logic        wdt_ie_reg;
	logic        wdt_en_reg;
	logic        wdt_if_reg;
	logic        wdt_ce_reg;
	logic [2:0]  ce_cnt_reg;
	logic        cause_wdt_reg;
	logic        cause_bod_reg;
	logic        cause_ext_reg;
	logic        cause_por_reg;
	logic        comparator_bandgap_select_reg;
	logic        wdt_en_eff;
	logic        wdt_running;
	logic        wdt_expire;
	logic        wb_hit;
	logic        wr_ctrl;
	logic        wr_cause;
	logic        wr_ref;
	logic [7:0]  wr_byte;
	logic [21:0] wdt_limit;

	// Brown-out off when fuse selects disabled level
	assign bod_enabled      = (BROWNOUT_LEVEL_FUSE_I[1:0] != rwc_pkg::BOD_LEVEL_OFF) ||
		BROWNOUT_LEVEL_FUSE_I[2];
	assign BROWNOUT_LEVEL_O = BROWNOUT_LEVEL_FUSE_I; // see R10

	rwc_sync_filter #(
		.CYCLES (BOD_FILTER)
	) u_bod_filter (
		.clk_i  (REF_CLK_I),
		.rst_i  (RST_I),
		.raw_i  (BOD_BELOW_LOW_I & bod_enabled),
		.filt_o (bod_low_filt)
	);

	// Hysteresis: set below low trip, clear above high trip
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			bod_active_reg <= 1'b0;
		end else if (!bod_enabled) begin
			bod_active_reg <= 1'b0;
		end else if (bod_low_filt) begin
			bod_active_reg <= 1'b1; // see R9
		end else if (BOD_ABOVE_HIGH_I) begin
			bod_active_reg <= 1'b0; // see R10
		end
	end

	assign ext_active = EXT_RESET_EN_I & ~EXT_RESET_N_I; // see R7

	// Four sources into one asynchronous reset
	assign src_rst = RST_I | SUPPLY_BELOW_POR_I | ext_active | bod_active_reg | wdt_pulse_reg; // see R4 R5

	// Oscillator tick enable at 128kHz
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			div_reg  <= '0;
			tick_reg <= 1'b0;
		end else if (div_reg == ($clog2(OSC_DIV+1))'(OSC_DIV - 1)) begin
			div_reg  <= '0;
			tick_reg <= 1'b1; // see R13
		end else begin
			div_reg  <= div_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	// Delay restarts when the last source releases
	rwc_delay_counter #(
		.WIDTH (DELAY_WIDTH)
	) u_delay (
		.clk_i     (REF_CLK_I),
		.src_rst_i (src_rst),
		.tick_i    (tick_reg),
		.length_i  (STARTUP_DELAY_I),
		.hold_o    (delay_hold)
	);

	assign INT_RESET_O = delay_hold; // see R3 R6 R8 R1
	assign IO_RESET_O  = src_rst | delay_hold; // see R2

	// Safety level two keeps the watchdog enabled
	assign wdt_en_eff  = wdt_en_reg | WATCHDOG_ALWAYS_ON_FUSE_I | cause_wdt_reg; // see R17
	assign wdt_running = wdt_en_eff | wdt_ie_reg; // see R20
	assign wdt_limit   = 22'(((1 << rwc_pkg::WDT_BASE_LOG2) << wdt_prescale_reg) - 1); // see R15
	assign wdt_expire  = wdt_running && tick_reg && (wdt_cnt_reg >= wdt_limit);

	// Watchdog counter cleared by restart, disable, reset
	always_ff @(posedge REF_CLK_I or posedge src_rst) begin
		if (src_rst) begin
			wdt_cnt_reg <= '0; // see R14
		end else if (!delay_hold && (WATCHDOG_RESTART_INSTRUCTION_I || !wdt_running)) begin
			wdt_cnt_reg <= '0; // see R14
		end else if (wdt_expire) begin
			wdt_cnt_reg <= '0;
		end else if (!delay_hold && tick_reg) begin
			wdt_cnt_reg <= wdt_cnt_reg + 1'b1; // see R13
		end
	end

	// One-cycle reset pulse on expiry in reset mode
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			wdt_pulse_reg <= 1'b0;
		end else begin
			wdt_pulse_reg <= wdt_expire && wdt_en_eff && !wdt_ie_reg && !wdt_pulse_reg; // see R12 R20
		end
	end
	assign WDT_RESET_PULSE_O = wdt_pulse_reg;

	// Wishbone decode, single-cycle acknowledge
	assign wb_hit   = CYC_I && STB_I && !ACK_O;
	assign wr_byte  = SEL_I[0] ? DAT_I[7:0] : 8'h00;
	assign wr_ctrl  = wb_hit && WE_I && SEL_I[0] && (ADR_I == rwc_pkg::WDT_CTRL_OFFSET);
	assign wr_cause = wb_hit && WE_I && SEL_I[0] && (ADR_I == rwc_pkg::RST_CAUSE_OFFSET);
	assign wr_ref   = wb_hit && WE_I && SEL_I[0] && (ADR_I == rwc_pkg::REF_CTRL_OFFSET);

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end else begin
			ACK_O <= wb_hit;
			if (wb_hit && !WE_I) begin
				case (ADR_I)
					rwc_pkg::WDT_CTRL_OFFSET: begin
						DAT_O <= {24'h000000, wdt_if_reg, wdt_ie_reg, wdt_prescale_reg[3], wdt_ce_reg,
							wdt_en_eff, wdt_prescale_reg[2:0]};
					end
					rwc_pkg::RST_CAUSE_OFFSET: begin
						DAT_O <= {28'h0000000, cause_wdt_reg, cause_bod_reg, cause_ext_reg, cause_por_reg};
					end
					rwc_pkg::REF_CTRL_OFFSET: begin
						DAT_O <= {31'h00000000, comparator_bandgap_select_reg};
					end
					default: begin
						DAT_O <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Watchdog control with timed change window
	always_ff @(posedge REF_CLK_I or posedge src_rst) begin
		if (src_rst) begin
			wdt_ce_reg       <= 1'b0; // see R1
			ce_cnt_reg       <= '0;
			wdt_prescale_reg <= 4'h0;
			wdt_ie_reg       <= 1'b0;
			wdt_en_reg       <= 1'b0;
		end else begin
			if (wdt_expire && wdt_en_eff && wdt_ie_reg) begin
				wdt_ie_reg <= 1'b0; // see R16
			end
			if (wr_ctrl) begin
				if (wr_byte[rwc_pkg::WDT_CE_BIT] && wr_byte[rwc_pkg::WDT_EN_BIT]) begin
					wdt_ce_reg <= 1'b1;
					ce_cnt_reg <= '0;
				end else begin
					wdt_ce_reg <= 1'b0;
				end
				wdt_ie_reg <= wr_byte[rwc_pkg::WDT_IE_BIT]; // see R16
				if (wr_byte[rwc_pkg::WDT_EN_BIT]) begin
					wdt_en_reg <= 1'b1;
				end else if (wdt_ce_reg) begin
					wdt_en_reg <= 1'b0; // see R17
				end
				if (!WATCHDOG_ALWAYS_ON_FUSE_I || wdt_ce_reg) begin
					wdt_prescale_reg <= {wr_byte[rwc_pkg::WDT_P3_BIT], wr_byte[2:0]}; // see R17
				end
			end else if (wdt_ce_reg) begin
				if (ce_cnt_reg == 3'(rwc_pkg::CE_WINDOW_CYCLES - 1)) begin
					wdt_ce_reg <= 1'b0; // see R19
				end else begin
					ce_cnt_reg <= ce_cnt_reg + 1'b1;
				end
			end
		end
	end

	// Interrupt flag: set wins over clear
	always_ff @(posedge REF_CLK_I or posedge src_rst) begin
		if (src_rst) begin
			wdt_if_reg <= 1'b0;
		end else if (wdt_expire && wdt_ie_reg) begin
			wdt_if_reg <= 1'b1; // see R16
		end else if (WDT_IRQ_ACK_I || (wr_ctrl && wr_byte[rwc_pkg::WDT_IF_BIT])) begin
			wdt_if_reg <= 1'b0;
		end
	end
	assign WDT_IRQ_O = wdt_if_reg & wdt_ie_reg;

	// Reset cause flags survive all but power-on
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cause_wdt_reg <= 1'b0;
			cause_bod_reg <= 1'b0;
			cause_ext_reg <= 1'b0;
			cause_por_reg <= 1'b1;
		end else begin
			if (SUPPLY_BELOW_POR_I) begin
				cause_wdt_reg <= 1'b0; // see R21
				cause_bod_reg <= 1'b0;
				cause_ext_reg <= 1'b0;
				cause_por_reg <= 1'b1;
			end else begin
				if (wdt_pulse_reg) begin
					cause_wdt_reg <= 1'b1; // see R21
				end else if (wr_cause && !wr_byte[rwc_pkg::CAUSE_WDT_BIT]) begin
					cause_wdt_reg <= 1'b0;
				end
				if (bod_active_reg) begin
					cause_bod_reg <= 1'b1;
				end else if (wr_cause && !wr_byte[rwc_pkg::CAUSE_BOD_BIT]) begin
					cause_bod_reg <= 1'b0;
				end
				if (ext_active) begin
					cause_ext_reg <= 1'b1;
				end else if (wr_cause && !wr_byte[rwc_pkg::CAUSE_EXT_BIT]) begin
					cause_ext_reg <= 1'b0;
				end
				if (wr_cause && !wr_byte[rwc_pkg::CAUSE_POR_BIT]) begin
					cause_por_reg <= 1'b0;
				end
			end
		end
	end

	// Comparator bandgap select
	always_ff @(posedge REF_CLK_I or posedge src_rst) begin
		if (src_rst) begin
			comparator_bandgap_select_reg <= 1'b0;
		end else if (wr_ref) begin
			comparator_bandgap_select_reg <= wr_byte[rwc_pkg::REF_COMPARATOR_BANDGAP_SELECT_BIT];
		end
	end

	assign BANDGAP_EN_O = bod_enabled | comparator_bandgap_select_reg | ADC_ENABLE_I; // see R18
endmodule

// >>> dv/rwc_checker.sv
// Port assertions for the reset and watchdog controller
`timescale 1ns/1ps
module rwc_checker #(
	parameter int DELAY_WIDTH = 16,
	parameter int OSC_DIV     = 781
) (
	// Clock, reset and sources
	input wire logic                   REF_CLK_I,
	input wire logic                   RST_I,
	input wire logic                   SUPPLY_BELOW_POR_I,
	input wire logic                   EXT_RESET_N_I,
	input wire logic                   EXT_RESET_EN_I,
	input wire logic                   BOD_BELOW_LOW_I,
	input wire logic [2:0]             BROWNOUT_LEVEL_FUSE_I,
	input wire logic [DELAY_WIDTH-1:0] STARTUP_DELAY_I,
	input wire logic                   ADC_ENABLE_I,
	// Results
	input wire logic                   INT_RESET_O,
	input wire logic                   IO_RESET_O,
	input wire logic                   WDT_RESET_PULSE_O,
	input wire logic                   BANDGAP_EN_O
);
	int quiet_cnt;
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			quiet_cnt <= 0;
		end else if (SUPPLY_BELOW_POR_I || (EXT_RESET_EN_I && !EXT_RESET_N_I)) begin
			quiet_cnt <= 0;
		end else if (quiet_cnt < 100000) begin
			quiet_cnt <= quiet_cnt + 1;
		end
	end
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_bod_low;
		BROWNOUT_LEVEL_FUSE_I != 3'h3 && BOD_BELOW_LOW_I;
	endsequence
	AST_POR_IMMEDIATE: assert property (SUPPLY_BELOW_POR_I |-> IO_RESET_O ##1 INT_RESET_O)
		else $error("power-on low without reset");
	AST_PIN_RESET: assert property (EXT_RESET_EN_I && !EXT_RESET_N_I |-> IO_RESET_O)
		else $error("enabled pin low without io reset");
	AST_STRETCH: assert property (quiet_cnt < STARTUP_DELAY_I * OSC_DIV |-> INT_RESET_O)
		else $error("internal reset released early");
	AST_WDT_ONE_CYCLE: assert property (WDT_RESET_PULSE_O |=> !WDT_RESET_PULSE_O)
		else $error("watchdog pulse longer than one cycle");
	AST_WDT_TO_RESET: assert property (WDT_RESET_PULSE_O |-> ##[0:2] INT_RESET_O)
		else $error("watchdog pulse did not reset");
	AST_BANDGAP_ON: assert property (BROWNOUT_LEVEL_FUSE_I != 3'h3 || ADC_ENABLE_I |-> BANDGAP_EN_O)
		else $error("bandgap off while needed");
	AST_BOD_PERSIST: assert property (s_bod_low [*8] |-> IO_RESET_O)
		else $error("persistent brown-out without reset");
	AST_BOD_FILTER: assert property ($rose(BOD_BELOW_LOW_I) && !IO_RESET_O |=> !IO_RESET_O [*2])
		else $error("brown-out dip not filtered");
endmodule

// >>> dv/rwc_partner.sv
// Behavioural supply detectors and reset pin
`timescale 1ns/1ps
module rwc_partner #(
	parameter int POR_MV  = 1400,
	parameter int BOT_MV  = 2700,
	parameter int HYST_MV = 100
) (
	// Supply level and pin request
	input  wire logic signed [31:0] supply_mv_i,
	input  wire logic               pin_req_i,
	// Detector and pin levels
	output logic                    below_por_o,
	output logic                    below_low_o,
	output logic                    above_high_o,
	output logic                    pin_n_o
);
	always_comb begin
		below_por_o  = supply_mv_i < POR_MV;
		below_low_o  = supply_mv_i < BOT_MV - HYST_MV / 2;
		above_high_o = supply_mv_i > BOT_MV + HYST_MV / 2;
		pin_n_o      = !pin_req_i;
	end
endmodule

// >>> dv/reset_and_watchdog_control_bench.sv
// Self-checking bench for the reset and watchdog controller
`timescale 1ns/1ps
module reset_and_watchdog_control_bench;
	localparam int OSC = 4;
	localparam int LO  = 8;
	localparam int HI  = 24;
	localparam int WDP = 8192;
	logic        clk, por, pin_n, blow, bhigh, ack, intr, ior, wpulse, irq, bg;
	logic        rst = 1'b1, pin_req = 1'b0, pen = 1'b1, aon = 1'b0, restart = 1'b0;
	logic        iack = 1'b0, adc = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [2:0]  fuse = 3'h3, blev;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat = 32'h0, rdat, q;
	int          supply_mv = 0, n_fail = 0, total_checks = 0, n;
	rwc_partner u_far (.supply_mv_i(supply_mv), .pin_req_i(pin_req), .below_por_o(por),
		.below_low_o(blow), .above_high_o(bhigh), .pin_n_o(pin_n));
	rwc_top #(.BOD_FILTER(3), .OSC_DIV(OSC)) dut (.REF_CLK_I(clk), .RST_I(rst), .SUPPLY_BELOW_POR_I(por),
		.EXT_RESET_N_I(pin_n), .EXT_RESET_EN_I(pen), .BOD_BELOW_LOW_I(blow), .BOD_ABOVE_HIGH_I(bhigh),
		.BROWNOUT_LEVEL_FUSE_I(fuse), .WATCHDOG_ALWAYS_ON_FUSE_I(aon), .STARTUP_DELAY_I(16'h2),
		.WATCHDOG_RESTART_INSTRUCTION_I(restart), .WDT_IRQ_ACK_I(iack), .ADC_ENABLE_I(adc), .CYC_I(cyc),
		.STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(dat), .DAT_O(rdat), .ACK_O(ack),
		.INT_RESET_O(intr), .IO_RESET_O(ior), .WDT_RESET_PULSE_O(wpulse), .WDT_IRQ_O(irq),
		.BANDGAP_EN_O(bg), .BROWNOUT_LEVEL_O(blev));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && k < 20) begin
			@(posedge clk);
			k++;
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task automatic rel(input string nm);
		n = 0;
		while (intr === 1'b1 && n < 500) begin
			@(posedge clk);
			n++;
		end
		chk(nm, {31'h0, n >= LO && n <= HI}, 32'h1);
	endtask
	task automatic t_por;
		supply_mv <= 3300;
		@(posedge clk);
		rel("por stretch");
		rc("ctrl init", 4'h0, 32'h0);
		rc("por flag", 4'h4, 32'h1);
		wb(1'b1, 4'h4, 32'h0);
		rc("flag clear", 4'h4, 32'h0);
		supply_mv <= 0;
		@(posedge clk);
		chk("por io", {31'h0, ior}, 32'h1);
		supply_mv <= 3300;
		@(posedge clk);
		rel("por again");
		wb(1'b1, 4'h4, 32'h0);
		$display("test por done");
	endtask
	task automatic t_pin;
		pen <= 1'b0;
		pin_req <= 1'b1;
		repeat (3) @(posedge clk);
		chk("pin off", {31'h0, ior}, 32'h0);
		pen <= 1'b1;
		repeat (3) @(posedge clk);
		chk("pin io", {31'h0, ior}, 32'h1);
		pin_req <= 1'b0;
		@(posedge clk);
		rel("pin stretch");
		rc("ext flag", 4'h4, 32'h2);
		wb(1'b1, 4'h4, 32'h0);
		$display("test pin done");
	endtask
	task automatic t_ref;
		for (int i = 0; i < 4; i++) begin
			adc <= i[0];
			wb(1'b1, 4'h8, {31'h0, i[1]});
			chk("bandgap", {31'h0, bg}, {31'h0, i[0] | i[1]});
		end
		adc <= 1'b0;
		fuse <= 3'h2;
		wb(1'b1, 4'h8, 32'h0);
		chk("bandgap bod", {31'h0, bg}, 32'h1);
		chk("level", {29'h0, blev}, 32'h2);
		$display("test ref done");
	endtask
	task automatic t_bod;
		supply_mv <= 2600;
		@(posedge clk);
		supply_mv <= 3300;
		repeat (10) @(posedge clk);
		rc("dip flag", 4'h4, 32'h0);
		supply_mv <= 2600;
		repeat (15) @(posedge clk);
		chk("bod io", {31'h0, ior}, 32'h1);
		supply_mv <= 2700;
		repeat (30) @(posedge clk);
		chk("band hold", {31'h0, intr}, 32'h1);
		supply_mv <= 3300;
		@(posedge clk);
		rel("bod stretch");
		rc("bod flag", 4'h4, 32'h4);
		wb(1'b1, 4'h4, 32'h0);
		$display("test bod done");
	endtask
	task automatic t_wdt;
		wb(1'b1, 4'h0, 32'h8);
		repeat (6000) @(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
		n = 1;
		while (wpulse !== 1'b1 && n < 9000) begin
			@(posedge clk);
			n++;
		end
		chk("period", {31'h0, n >= WDP - 8 && n <= WDP + 12}, 32'h1);
		@(posedge clk);
		chk("pulse", {31'h0, wpulse}, 32'h0);
		rel("wdt stretch");
		rc("forced en", 4'h0, 32'h8);
		rc("wdt flag", 4'h4, 32'h8);
		wb(1'b1, 4'h4, 32'h0);
		wb(1'b1, 4'h0, 32'h18);
		repeat (6) @(posedge clk);
		wb(1'b1, 4'h0, 32'h0);
		rc("late off", 4'h0, 32'h8);
		wb(1'b1, 4'h0, 32'h18);
		wb(1'b1, 4'h0, 32'h0);
		rc("timed off", 4'h0, 32'h0);
		$display("test wdt done");
	endtask
	task automatic t_irq;
		wb(1'b1, 4'h0, 32'h40);
		n = 0;
		while (irq !== 1'b1 && n < 9000) begin
			@(posedge clk);
			n++;
		end
		chk("irq time", {31'h0, n >= WDP - 16 && n <= WDP + 12}, 32'h1);
		chk("no reset", {31'h0, intr}, 32'h0);
		iack <= 1'b1;
		@(posedge clk);
		iack <= 1'b0;
		repeat (2) @(posedge clk);
		chk("irq ack", {31'h0, irq}, 32'h0);
		wb(1'b1, 4'h0, 32'h0);
		aon <= 1'b1;
		@(posedge clk);
		rc("lvl2 en", 4'h0, 32'h8);
		wb(1'b1, 4'h0, 32'h18);
		wb(1'b1, 4'h0, 32'h0);
		rc("lvl2 keep", 4'h0, 32'h8);
		$display("test irq done");
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#500000;
		n_fail++;
		end_of_test;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_por;
		t_pin;
		t_ref;
		t_bod;
		t_wdt;
		t_irq;
		end_of_test;
	end
endmodule
bind rwc_top rwc_checker #(.DELAY_WIDTH(DELAY_WIDTH), .OSC_DIV(OSC_DIV)) u_chk (.REF_CLK_I(REF_CLK_I),
	.RST_I(RST_I), .SUPPLY_BELOW_POR_I(SUPPLY_BELOW_POR_I), .EXT_RESET_N_I(EXT_RESET_N_I),
	.EXT_RESET_EN_I(EXT_RESET_EN_I), .BOD_BELOW_LOW_I(BOD_BELOW_LOW_I), .ADC_ENABLE_I(ADC_ENABLE_I),
	.BROWNOUT_LEVEL_FUSE_I(BROWNOUT_LEVEL_FUSE_I), .STARTUP_DELAY_I(STARTUP_DELAY_I), .INT_RESET_O(INT_RESET_O),
	.IO_RESET_O(IO_RESET_O), .WDT_RESET_PULSE_O(WDT_RESET_PULSE_O), .BANDGAP_EN_O(BANDGAP_EN_O));
